// *** logic/rfseq_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the rail fault sequencer.
// Assumes: A 10 MHz system clock.
// Notes: Register offsets are word addresses on the plain register port.
`ifndef RFSEQ_CFG_SVH
`define RFSEQ_CFG_SVH
`define RFSEQ_TARGET_ADDR     7'h6b
`define RFSEQ_OFS_FREQ        8'h01
`define RFSEQ_OFS_PROT        8'h14
`define RFSEQ_OFS_STATUS      8'h20
`define RFSEQ_OFS_MASK        8'h21
`define RFSEQ_OFS_STATE       8'h22
`define RFSEQ_FREQ_RST        2'h0
`define RFSEQ_PROT_RST        2'h3
`define RFSEQ_PROT_SHORT_BIT  0
`define RFSEQ_PROT_UV_BIT     1
`define RFSEQ_CLK_KHZ         10000
`define RFSEQ_TICK_US         100
`define RFSEQ_TICK_CYC        ((`RFSEQ_CLK_KHZ * `RFSEQ_TICK_US) / 1000)
`define RFSEQ_CHECK_MS        1
`define RFSEQ_PRE_MS          4
`define RFSEQ_UV_MS           50
`define RFSEQ_CHECK_TICKS     (`RFSEQ_CHECK_MS * 1000 / `RFSEQ_TICK_US)
`define RFSEQ_PRE_TICKS       (`RFSEQ_PRE_MS * 1000 / `RFSEQ_TICK_US)
`define RFSEQ_UV_TICKS        (`RFSEQ_UV_MS * 1000 / `RFSEQ_TICK_US)
`define RFSEQ_XRAIL_TICKS     1
`endif

// *** logic/rfseq_pkg.sv ***
// Purpose: Types of the rail fault sequencer.
// Assumes: Nothing beyond the configuration header.
// Notes: Sequencer states are one-hot.
package rfseq_pkg;
   typedef enum logic [5:0] {
      ST_OFF   = 6'h01,
      ST_CHECK = 6'h02,
      ST_WAIT  = 6'h04,
      ST_PRE   = 6'h08,
      ST_RUN   = 6'h10,
      ST_SHUT  = 6'h20
   } rfseq_state_t;
endpackage : rfseq_pkg

// *** logic/rfseq_top.sv ***
// Purpose: Power sequencing and rail fault supervision of a display power module.
// Assumes: Comparator outputs and soft-start flags arrive from analog, asynchronous.
// Notes: Rail order is positive source, negative source, gate high, gate low.
// Summary of operation
// RL1 - The serial slave answers at 7-bit address 1101011, exposed as target_addr.
// RL2 - The enable pin starts the power-on sequence and its removal the power-off.
// RL3 - A 2-bit frequency field picks 600k, 800k, 1M or 2.2MHz and resets to zero.
// RL4 - A rail below 70% starts a timer and after 50ms the whole device shuts down.
// RL5 - Undervoltage watch of a rail starts at the end of its soft-start.
// RL6 - A fault shutdown stays latched until lockout release or an enable restart.
// RL7 - Bit 1 of register 14h enables undervoltage protection.
// RL8 - Bit 0 of register 14h enables short protection.
// RL9 - Power-on waits until every output is below its short level.
// RL10 - The positive rail uses the fixed early level before soft-start, 30% after.
// RL11 - The below-short check is judged 1ms after lockout release.
// RL12 - The positive rail is checked 4ms after its delay; below early level shuts down.
// RL13 - Pre-charge ends and soft-start starts once the rail is within 0.2V of input.
// RL14 - Positive rail short watch runs in soft-start; others arm after their soft-start.
// RL15 - A rail under 30% stops at once, others 100us later, fault pin goes low; here the others stop on the second 100us tick after the trip.
// RL16 - A 100us tick from the clock times all fault windows.
`timescale 1ns/1ns
`include "rfseq_cfg.svh"
module rfseq_top (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             irq,
   input  wire logic        enable_pin,
   input  wire logic        input_lockout_n,
   input  wire logic        delay_done,
   input  wire logic        precharge_ok,
   input  wire logic [3:0]  ss_done,
   input  wire logic [3:0]  above_short,
   input  wire logic [3:0]  above_uv,
   input  wire logic        pos_above_early,
   output logic      [6:0]  target_addr,
   output logic      [1:0]  freq_sel,
   output logic             power_on,
   output logic             precharge,
   output logic      [3:0]  rail_switch_en,
   output logic             fault_n_o,
   output logic             fault_n_oe
);
   // Two-flop synchronisers for every analog or pin input.
   logic [15:0] sync1_q, sync2_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end else if (clk_en) begin
         sync1_q <= {enable_pin, input_lockout_n, delay_done, precharge_ok, ss_done,
                     above_short, above_uv};
         sync2_q <= sync1_q;
      end
   end
   wire       en_s     = sync2_q[15];
   wire       lock_ok  = sync2_q[14];
   wire       dly_s    = sync2_q[13];
   wire       pre_ok_s = sync2_q[12];
   wire [3:0] ss_s     = sync2_q[11:8];
   wire [3:0] sc_s     = sync2_q[7:4];
   wire [3:0] uv_s     = sync2_q[3:0];
   logic early1_q, early2_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         early1_q <= 1'b0;
         early2_q <= 1'b0;
      end else if (clk_en) begin
         early1_q <= pos_above_early;
         early2_q <= early1_q;
      end
   end

   // RL16 timebase tick
   // A shared 100us tick keeps every window counter narrow; windows are exact to one tick.
   logic [9:0] tick_cnt_q;
   wire        tick = (tick_cnt_q == 10'(`RFSEQ_TICK_CYC - 1));
   always_ff @(posedge clock) begin
      if (!nrst) tick_cnt_q <= 10'h000;
      else if (clk_en) tick_cnt_q <= tick ? 10'h000 : tick_cnt_q + 10'h001;
   end

   // Register file.
   logic [1:0] freq_q, prot_q;
   logic [2:0] sts_q, msk_q;
   logic       en_d1_q, lock_d1_q;
   wire        hit_freq = (reg_addr == `RFSEQ_OFS_FREQ);
   wire        hit_prot = (reg_addr == `RFSEQ_OFS_PROT);
   wire        hit_sts  = (reg_addr == `RFSEQ_OFS_STATUS);
   wire        hit_msk  = (reg_addr == `RFSEQ_OFS_MASK);
   wire        hit_st   = (reg_addr == `RFSEQ_OFS_STATE);
   // RL7 undervoltage enable
   wire        uv_en = prot_q[`RFSEQ_PROT_UV_BIT];
   // RL8 short enable
   wire        sc_en = prot_q[`RFSEQ_PROT_SHORT_BIT];

   // RL2 enable edges
   wire en_rise   = en_s & ~en_d1_q;
   wire lock_rise = lock_ok & ~lock_d1_q;

   rfseq_pkg::rfseq_state_t st_q, st_d;
   logic [9:0] win_q;
   logic [3:0] sw_q;
   logic       xrail_q;
   logic [0:0] xcnt_q;
   logic       fault_q;
   logic       pre_done_q;
   logic [9:0] uvc_q [4];
   logic [3:0] uv_trip;
   logic [3:0] sc_trip;

   // RL10 short levels per rail
   // Positive rail compares to the fixed early level until its soft-start finishes.
   wire pos_above = ss_s[0] ? sc_s[0] : early2_q;
   wire [3:0] above_lvl = {sc_s[3:1], pos_above};
   wire all_below = ~|above_lvl;

   // RL4 RL5 undervoltage timers
   // A rail that never rises after soft-start counts down the same 50ms window.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_uv
         wire watch = uv_en && (st_q == rfseq_pkg::ST_RUN) && ss_s[g] && !uv_s[g];
         always_ff @(posedge clock) begin
            if (!nrst) uvc_q[g] <= 10'h000;
            else if (clk_en) begin
               if (!watch) uvc_q[g] <= 10'h000;
               else if (tick && uvc_q[g] != 10'(`RFSEQ_UV_TICKS))
                  uvc_q[g] <= uvc_q[g] + 10'h001;
            end
         end
         assign uv_trip[g] = (uvc_q[g] == 10'(`RFSEQ_UV_TICKS));
         // RL14 short arming
         // The positive rail is watched through soft-start; others only after theirs.
         assign sc_trip[g] = sc_en && (st_q == rfseq_pkg::ST_RUN) && !above_lvl[g]
                           && ((g == 0) ? !pre_done_q ? 1'b0 : 1'b1 : ss_s[g]);
      end
   endgenerate

   wire any_uv = |uv_trip;
   wire any_sc = |sc_trip;
   // RL12 pre-charge early check
   wire pre_fail = sc_en && (st_q == rfseq_pkg::ST_PRE) && dly_s
                 && (win_q == 10'(`RFSEQ_PRE_TICKS)) && !early2_q;

   // Sequencer next state.
   always_comb begin
      st_d = st_q;
      case (st_q)
         rfseq_pkg::ST_OFF:   if (lock_ok && en_s) st_d = rfseq_pkg::ST_CHECK;
         // RL11 judged at 1ms
         rfseq_pkg::ST_CHECK: if (win_q == 10'(`RFSEQ_CHECK_TICKS)) st_d = rfseq_pkg::ST_WAIT;
         // RL9 wait all below
         rfseq_pkg::ST_WAIT:  if (all_below) st_d = rfseq_pkg::ST_PRE;
         // RL13 pre-charge exit
         rfseq_pkg::ST_PRE:   if (pre_fail) st_d = rfseq_pkg::ST_SHUT;
                              else if (pre_ok_s) st_d = rfseq_pkg::ST_RUN;
         rfseq_pkg::ST_RUN:   if (any_uv || any_sc) st_d = rfseq_pkg::ST_SHUT;
         // RL6 latched shutdown
         rfseq_pkg::ST_SHUT:  st_d = rfseq_pkg::ST_SHUT;
         default:             st_d = rfseq_pkg::ST_OFF;
      endcase
      // RL2 enable control
      if (!lock_ok || !en_s) st_d = rfseq_pkg::ST_OFF;
      else if (lock_rise || en_rise) st_d = rfseq_pkg::ST_CHECK;
   end

   // State, window counter and edge history.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_q <= rfseq_pkg::ST_OFF;
         win_q <= 10'h000;
         en_d1_q <= 1'b0;
         lock_d1_q <= 1'b0;
         pre_done_q <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         en_d1_q <= en_s;
         lock_d1_q <= lock_ok;
         if (st_d != st_q) win_q <= 10'h000;
         else if (tick && (st_q != rfseq_pkg::ST_PRE || dly_s) && win_q != 10'h3ff)
            win_q <= win_q + 10'h001;
         pre_done_q <= (st_d == rfseq_pkg::ST_RUN);
      end
   end

   // RL15 staged switch stop
   // The faulty rail stops at once, the rest at the second 100us tick after the trip.
   wire trip_now = (st_q == rfseq_pkg::ST_RUN) && (st_d == rfseq_pkg::ST_SHUT);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sw_q <= 4'h0;
         xrail_q <= 1'b0;
         xcnt_q <= 1'b0;
         fault_q <= 1'b0;
      end else if (clk_en) begin
         if (trip_now) begin
            sw_q <= sw_q & ~(sc_trip | uv_trip);
            xrail_q <= 1'b1;
            xcnt_q <= 1'b0;
         end else if (xrail_q) begin
            if (tick) begin
               if (xcnt_q == 1'(`RFSEQ_XRAIL_TICKS)) begin
                  sw_q <= 4'h0;
                  xrail_q <= 1'b0;
                  fault_q <= 1'b1;
               end else xcnt_q <= xcnt_q + 1'b1;
            end
         end else if (st_q == rfseq_pkg::ST_RUN) sw_q <= ss_s | 4'h1;
         else if (st_q == rfseq_pkg::ST_SHUT) begin
            sw_q <= 4'h0;
            fault_q <= 1'b1;
         end else begin
            sw_q <= 4'h0;
            fault_q <= 1'b0;
         end
      end
   end

   // Events: bit0 undervoltage, bit1 short, bit2 shutdown; a status read clears, set wins.
   wire [2:0] ev = {trip_now | pre_fail, any_sc & trip_now, any_uv & trip_now};
   wire       rd_sts = reg_rd && hit_sts;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         freq_q <= `RFSEQ_FREQ_RST;
         prot_q <= `RFSEQ_PROT_RST;
         sts_q <= 3'h0;
         msk_q <= 3'h0;
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         // RL3 frequency write
         if (reg_wr && hit_freq) freq_q <= reg_wdata[1:0];
         if (reg_wr && hit_prot) prot_q <= reg_wdata[1:0];
         if (reg_wr && hit_msk) msk_q <= reg_wdata[2:0];
         sts_q <= (rd_sts ? 3'h0 : sts_q) | ev;
         reg_rdata <= !reg_rd ? 8'h00 :
                      hit_freq ? {6'h00, freq_q} :
                      hit_prot ? {6'h00, prot_q} :
                      hit_sts  ? {5'h00, sts_q} :
                      hit_msk  ? {5'h00, msk_q} :
                      hit_st   ? {2'h0, st_q} : 8'h00;
      end
   end

   // Outputs.
   assign irq = |(sts_q & msk_q);
   // RL1 slave address
   assign target_addr = `RFSEQ_TARGET_ADDR;
   assign freq_sel = freq_q;
   assign power_on = sw_q[0];
   assign precharge = (st_q == rfseq_pkg::ST_PRE);
   assign rail_switch_en = sw_q;
   // Open-drain fault pin: driven low only while faulted.
   assign fault_n_o = 1'b0;
   assign fault_n_oe = fault_q;

   // RL6 shutdown stays latched
   a_shut_latched: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == rfseq_pkg::ST_SHUT && clk_en && lock_ok && en_s && !$rose(en_s)
       && $past(lock_ok) && $past(en_s)) |=> st_q == rfseq_pkg::ST_SHUT) // RL6
      else $error("Shutdown left without restart.");
   // RL15 fault pin low after shutdown
   a_fault_pin: assert property (@(posedge clock) disable iff (!nrst)
      fault_n_oe |-> rail_switch_en == 4'h0) // RL15
      else $error("Fault pin low while rails still switch.");
   // RL3 frequency reset value
   a_freq_rst: assert property (@(posedge clock) $rose(nrst) |-> freq_sel == 2'h0) // RL3
      else $error("Frequency field not reset to zero.");
   // RL9 pre-charge needs all below
   a_wait_below: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == rfseq_pkg::ST_WAIT && !all_below && clk_en && lock_ok && en_s)
      |=> st_q != rfseq_pkg::ST_PRE) // RL9
      else $error("Pre-charge entered with an output above short level.");
   // RL13 soft-start only after pre-charge ok
   a_pre_exit: assert property (@(posedge clock) disable iff (!nrst)
      $rose(st_q == rfseq_pkg::ST_RUN) |-> $past(pre_ok_s)) // RL13
      else $error("Soft-start began before pre-charge finished.");
   // RL2 off without enable
   a_en_off: assert property (@(posedge clock) disable iff (!nrst)
      (!en_s && clk_en) |=> st_q == rfseq_pkg::ST_OFF) // RL2
      else $error("Sequence running without enable.");
   // RL7 no undervoltage trip when disabled
   a_uv_off: assert property (@(posedge clock) disable iff (!nrst)
      !uv_en |-> !any_uv) // RL7
      else $error("Undervoltage trip while disabled.");
   // RL8 no short trip when disabled
   a_sc_off: assert property (@(posedge clock) disable iff (!nrst)
      !sc_en |-> !any_sc && !pre_fail) // RL8
      else $error("Short trip while disabled.");
   // RL15 tripped rail stops at once
   a_trip_stop: assert property (@(posedge clock) disable iff (!nrst)
      (trip_now && clk_en) |=> (rail_switch_en & $past(sc_trip | uv_trip)) == 4'h0) // RL15
      else $error("Tripped rail kept switching.");
endmodule : rfseq_top

// *** bench/rfseq_rails.sv ***
// Purpose: Behavioural rails and comparators on the far side of the rail fault sequencer.
// Assumes: All rails follow the positive rail switch enable, rail_switch_en[0], after a short soft-start.
// Notes: Bench knobs hold a rail high before power-up or pull a running rail low.
`timescale 1ns/1ns
module rfseq_rails (
   input  wire logic       clock,
   input  wire logic [3:0] rail_switch_en,
   input  wire logic       precharge,
   input  wire logic [3:0] hold_high,
   input  wire logic [3:0] pull_low,
   input  wire logic       early_ok,
   input  wire logic       charge_ok,
   output logic            delay_done,
   output logic            precharge_ok,
   output logic      [3:0] ss_done,
   output logic      [3:0] above_short,
   output logic      [3:0] above_uv,
   output logic            pos_above_early
);
   logic [5:0] ss_q;
   // Soft-start lasts 32 cycles, far shorter than a real ramp, so runs stay short.
   always_ff @(posedge clock) begin
      ss_q <= !rail_switch_en[0] ? 6'h00 : (ss_q[5] ? ss_q : ss_q + 6'h01);
   end
   assign ss_done = ss_q[5] ? 4'hf : 4'h0;
   // residual charge: a held rail reads above its levels whatever the switches do.
   // The levels move with the soft-start flags so that no rail looks collapsed for a cycle.
   assign above_short = (ss_done & ~pull_low) | hold_high;
   assign above_uv    = (ss_done & ~pull_low) | hold_high;
   // pre-charge comparators: the delay ends at once, the rail only when allowed.
   always_ff @(posedge clock) begin
      delay_done      <= precharge;
      precharge_ok    <= precharge & charge_ok;
      // The delayed flag bridges the cycle between pre-charge end and the first switch enable.
      pos_above_early <= early_ok & (precharge | delay_done | rail_switch_en[0]);
   end
endmodule : rfseq_rails

// *** bench/tb_rail_fault_sequencer.sv ***
// Purpose: Self-checking bench of the rail fault sequencer through its register port.
// Assumes: A 10 MHz clock; the undervoltage window is too long to run in full.
// Notes: State is watched by polling the state register under bounded counts.
`timescale 1ns/1ns
`include "rfseq_cfg.svh"
module tb_rail_fault_sequencer;
   logic       clock, nrst, clk_en, reg_wr, reg_rd, irq, enable_pin, input_lockout_n;
   logic       delay_done, precharge_ok, pos_above_early, power_on, precharge;
   logic       fault_n_o, fault_n_oe, early_ok, charge_ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [3:0] ss_done, above_short, above_uv, rail_switch_en, hold_high, pull_low;
   logic [6:0] target_addr;
   logic [1:0] freq_sel;
   int         miscompares, n_tests;

   rfseq_top u_rfseq_top (.clock, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .enable_pin, .input_lockout_n, .delay_done, .precharge_ok, .ss_done,
      .above_short, .above_uv, .pos_above_early, .target_addr, .freq_sel, .power_on,
      .precharge, .rail_switch_en, .fault_n_o, .fault_n_oe);
   rfseq_rails u_rfseq_rails (.clock, .rail_switch_en, .precharge, .hold_high, .pull_low,
      .early_ok, .charge_ok, .delay_done, .precharge_ok, .ss_done, .above_short, .above_uv,
      .pos_above_early);

   // The clock toggles every half period of 50 ns.
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      n_tests++;
      if (seen !== want) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are sampled just past it.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
      logic [7:0] v;
      rd(a, v);
      check(v, want);
   endtask : rd_chk

   task automatic wait_state(input logic [7:0] want, input int polls);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < polls && v !== want; i++) rd(`RFSEQ_OFS_STATE, v);
      check(v, want);
   endtask : wait_state

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // The full run needs about 65k cycles; the limit leaves a margin above that.
   initial begin
      #9000000;
      miscompares++;
      complete_run();
   end

   // Main sequence: registers, a held rail, a short in operation, a failed pre-charge.
   initial begin
      {nrst, reg_wr, reg_rd, enable_pin, early_ok, charge_ok} = 6'h00;
      {clk_en, input_lockout_n} = 2'h3;
      {reg_addr, reg_wdata, hold_high, pull_low} = 24'h000000;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      check({1'b0, target_addr}, 8'h6b);
      rd_chk(`RFSEQ_OFS_PROT, 8'h03);
      rd_chk(`RFSEQ_OFS_STATE, 8'h01);
      rd_chk(`RFSEQ_OFS_FREQ, 8'h00);
      wr(8'h7f, 8'hff);
      rd_chk(8'h7f, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wr(`RFSEQ_OFS_FREQ, 8'(f));
         rd_chk(`RFSEQ_OFS_FREQ, 8'(f));
         check({6'h00, freq_sel}, 8'(f));
      end
      hold_high  <= 4'h4;
      early_ok   <= 1'b1;
      enable_pin <= 1'b1;
      repeat (5000) @(posedge clock);
      rd_chk(`RFSEQ_OFS_STATE, 8'h02);
      wait_state(8'h04, 5000);
      repeat (1000) @(posedge clock);
      rd_chk(`RFSEQ_OFS_STATE, 8'h04);
      hold_high <= 4'h0;
      wait_state(8'h08, 20);
      check({7'h00, precharge}, 8'h01);
      charge_ok <= 1'b1;
      wait_state(8'h10, 20);
      repeat (40) @(posedge clock);
      check({4'h0, rail_switch_en}, 8'h0f);
      // A collapsed rail is ignored while short watch is off.
      wr(`RFSEQ_OFS_PROT, 8'h02);
      pull_low <= 4'h8;
      repeat (20) @(posedge clock);
      rd_chk(`RFSEQ_OFS_STATE, 8'h10);
      pull_low <= 4'h0;
      wr(`RFSEQ_OFS_PROT, 8'h03);
      rd(`RFSEQ_OFS_STATUS, d);
      pull_low <= 4'h8;
      repeat (8) @(posedge clock);
      check({4'h0, rail_switch_en}, 8'h07);
      repeat (2500) @(posedge clock);
      check({4'h0, rail_switch_en}, 8'h00);
      check({7'h00, fault_n_oe}, 8'h01);
      rd_chk(`RFSEQ_OFS_STATE, 8'h20);
      check({7'h00, irq}, 8'h00);
      wr(`RFSEQ_OFS_MASK, 8'h06);
      rd_chk(`RFSEQ_OFS_MASK, 8'h06);
      check({7'h00, irq}, 8'h01);
      rd_chk(`RFSEQ_OFS_STATUS, 8'h06);
      check({7'h00, irq}, 8'h00);
      pull_low <= 4'h0;
      repeat (100) @(posedge clock);
      rd_chk(`RFSEQ_OFS_STATE, 8'h20);
      enable_pin <= 1'b0;
      wait_state(8'h01, 50);
      check({4'h0, rail_switch_en}, 8'h00);
      // Second power-up: the rail never passes its early level during pre-charge.
      wr(`RFSEQ_OFS_PROT, 8'h01);
      rd_chk(`RFSEQ_OFS_PROT, 8'h01);
      charge_ok  <= 1'b0;
      early_ok   <= 1'b0;
      enable_pin <= 1'b1;
      wait_state(8'h08, 8000);
      repeat (35000) @(posedge clock);
      rd_chk(`RFSEQ_OFS_STATE, 8'h08);
      wait_state(8'h20, 5000);
      input_lockout_n <= 1'b0;
      wait_state(8'h01, 50);
      complete_run();
   end
endmodule : tb_rail_fault_sequencer
